// ---- rtl/cbc_pkg.sv ----
// Package of register map, field layout and constants for the capability and brown-out block.
package cbc_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] ADDR_PERIPHERAL_PRESENCE_B = 12'h014;
    localparam logic [11:0] ADDR_PIN_PRESENCE = 12'h018;
    localparam logic [11:0] ADDR_PORT_PRESENCE = 12'h01C;
    localparam logic [11:0] ADDR_BROWNOUT_CONTROL = 12'h030;
    localparam int ADDR_W = 12;

    // ****************************************************************
    // Fixed capability values
    // ****************************************************************
    localparam logic [31:0] PERIPHERAL_PRESENCE_B_VALUE = 32'h0107_0113;
    localparam logic [31:0] PIN_PRESENCE_VALUE = 32'h173F_01FF;
    localparam logic [31:0] PORT_PRESENCE_VALUE = 32'h0000_001F;

    // ****************************************************************
    // Brown-out control fields
    // ****************************************************************
    localparam int FILTER_COUNT_LSB = 2;
    localparam int FILTER_COUNT_MSB = 15;
    localparam int RESET_SELECT_BIT = 1;
    localparam int NOISE_CHECK_BIT = 0;
    localparam int LANE_W = 8;
    localparam int FILTER_COUNT_W = FILTER_COUNT_MSB - FILTER_COUNT_LSB + 1;
    localparam int FILTER_LOW_W = LANE_W - FILTER_COUNT_LSB;
    localparam logic [13:0] FILTER_COUNT_RESET = 14'h1FFF;
    localparam logic RESET_SELECT_RESET = 1'b0;
    localparam logic NOISE_CHECK_RESET = 1'b1;

    localparam logic [1:0] RESP_OKAY = 2'h0;

    typedef enum logic [1:0] {
        FLT_IDLE,
        FLT_WAIT,
        FLT_HOLD
    } cbc_filter_state_type;
endpackage

// ---- rtl/cbc_capability_brownout.sv ----
// Capability registers and brown-out filter with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps

module cbc_capability_brownout (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [cbc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cbc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic brownout_detector,
    input wire logic internal_oscillator,
    output logic brownout_reset_req,
    output logic brownout_irq_req
);
    import cbc_pkg::*;

    // ****************************************************************
    // Register slave
    // ****************************************************************
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_arready, next_rvalid, next_awready, next_wready;
    logic [31:0] next_rdata;
    logic [13:0] brownout_filter_count, next_filter_count;
    logic brownout_reset_select, next_reset_select;
    logic brownout_noise_check, next_noise_check;
    logic do_write;

    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                              input logic [31:0] ctl);
        unique case (a)
            ADDR_PERIPHERAL_PRESENCE_B: read_word = PERIPHERAL_PRESENCE_B_VALUE;
            ADDR_PIN_PRESENCE: read_word = PIN_PRESENCE_VALUE;
            ADDR_PORT_PRESENCE: read_word = PORT_PRESENCE_VALUE;
            ADDR_BROWNOUT_CONTROL: read_word = ctl;
            default: read_word = 32'h0000_0000;
        endcase
    endfunction

    logic [31:0] ctl_word;
    always_comb begin
        ctl_word = 32'h0000_0000;
        ctl_word[FILTER_COUNT_MSB:FILTER_COUNT_LSB] = brownout_filter_count;
        ctl_word[RESET_SELECT_BIT] = brownout_reset_select;
        ctl_word[NOISE_CHECK_BIT] = brownout_noise_check;
    end

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_filter_count = brownout_filter_count;
        next_reset_select = brownout_reset_select;
        next_noise_check = brownout_noise_check;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            // Capability offsets fall through: the write is dropped but still answered.
            if (aw_addr == ADDR_BROWNOUT_CONTROL) begin
                if (w_strb[0]) begin
                    next_filter_count[FILTER_LOW_W-1:0] = w_data[LANE_W-1:FILTER_COUNT_LSB];
                    next_reset_select = w_data[RESET_SELECT_BIT];
                    next_noise_check = w_data[NOISE_CHECK_BIT];
                end
                if (w_strb[1]) begin
                    next_filter_count[FILTER_COUNT_W-1:FILTER_LOW_W] = w_data[FILTER_COUNT_MSB:LANE_W];
                end
            end
            next_bvalid = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    always_comb begin
        next_arready = 1'b0;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = read_word(s_axi_araddr, ctl_word);
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end else if (!s_axi_rvalid && s_axi_arvalid && !s_axi_arready) begin
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            brownout_filter_count <= FILTER_COUNT_RESET;
            brownout_reset_select <= RESET_SELECT_RESET;
            brownout_noise_check <= NOISE_CHECK_RESET;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            brownout_filter_count <= next_filter_count;
            brownout_reset_select <= next_reset_select;
            brownout_noise_check <= next_noise_check;
        end
    end

    // Ready is a registered copy of the inverted next held flag, gated by bvalid, so each channel takes one item per write.
    assign s_axi_bresp = RESP_OKAY;
    assign s_axi_rresp = RESP_OKAY;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [2:0] det_sync, osc_sync;
    logic det_level, next_det_level, osc_level, next_osc_level;
    logic osc_tick;

    always_comb begin
        next_det_level = det_level;
        next_osc_level = osc_level;
        if (det_sync[1] == det_sync[2]) begin
            next_det_level = det_sync[2];
        end
        if (osc_sync[1] == osc_sync[2]) begin
            next_osc_level = osc_sync[2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_sync <= 3'h0;
            osc_sync <= 3'h0;
            det_level <= 1'b0;
            osc_level <= 1'b0;
        end else begin
            det_sync <= {det_sync[1:0], brownout_detector};
            osc_sync <= {osc_sync[1:0], internal_oscillator};
            det_level <= next_det_level;
            osc_level <= next_osc_level;
        end
    end

    // One tick per internal oscillator period, taken on its rising edge.
    assign osc_tick = next_osc_level && !osc_level;

    // ****************************************************************
    // Brown-out filter
    // ****************************************************************
    cbc_filter_state_type state, next_state;
    logic [13:0] wait_count, next_wait_count;
    logic next_reset_req, next_irq_req;
    logic report;

    always_comb begin
        next_state = state;
        next_wait_count = wait_count;
        report = 1'b0;
        unique case (state)
            FLT_IDLE: begin
                if (det_level) begin
                    if (brownout_noise_check) begin
                        next_state = FLT_WAIT;
                        next_wait_count = brownout_filter_count;
                    end else begin
                        report = 1'b1;
                        next_state = FLT_HOLD;
                    end
                end
            end
            FLT_WAIT: begin
                if (wait_count == 14'h0000) begin
                    // a deasserted detector here is dropped as noise.
                    next_state = det_level ? FLT_HOLD : FLT_IDLE;
                    report = det_level;
                end else if (osc_tick) begin
                    next_wait_count = wait_count - 14'h0001;
                end
            end
            FLT_HOLD: begin
                // Report held every cycle while the detector stays asserted; rearm once the detector falls.
                report = det_level;
                if (!det_level) begin
                    next_state = FLT_IDLE;
                end
            end
        endcase
        next_reset_req = report && brownout_reset_select;
        next_irq_req = report && !brownout_reset_select;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= FLT_IDLE;
            wait_count <= 14'h0000;
            brownout_reset_req <= 1'b0;
            brownout_irq_req <= 1'b0;
        end else begin
            state <= next_state;
            wait_count <= next_wait_count;
            brownout_reset_req <= next_reset_req;
            brownout_irq_req <= next_irq_req;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_cap_read;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_PORT_PRESENCE)
        |=> s_axi_rvalid && s_axi_rdata == PORT_PRESENCE_VALUE;
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("port presence misread");

    property p_cap_const;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_PIN_PRESENCE)
        |=> s_axi_rdata == PIN_PRESENCE_VALUE;
    endproperty
    a_cap_const: assert property (p_cap_const) else $error("pin presence misread");

    property p_nocheck_now;
        @(posedge aclk) disable iff (!aresetn)
        (state == FLT_IDLE && det_level && !brownout_noise_check)
        |=> (brownout_reset_req || brownout_irq_req);
    endproperty
    a_nocheck_now: assert property (p_nocheck_now) else $error("no immediate report");

    property p_noise_drop;
        @(posedge aclk) disable iff (!aresetn)
        (state == FLT_WAIT && wait_count == 14'h0000 && !det_level)
        |=> !brownout_reset_req && !brownout_irq_req && state == FLT_IDLE;
    endproperty
    a_noise_drop: assert property (p_noise_drop) else $error("noise reported");

    property p_wait_quiet;
        @(posedge aclk) disable iff (!aresetn)
        (state == FLT_WAIT && wait_count != 14'h0000) |=> !brownout_reset_req && !brownout_irq_req;
    endproperty
    a_wait_quiet: assert property (p_wait_quiet) else $error("report during wait");

    property p_select;
        @(posedge aclk) disable iff (!aresetn)
        brownout_reset_req |-> $past(brownout_reset_select) && !brownout_irq_req;
    endproperty
    a_select: assert property (p_select) else $error("wrong signal method");

    property p_cap_write;
        @(posedge aclk) disable iff (!aresetn)
        (do_write && aw_addr != ADDR_BROWNOUT_CONTROL) |=> $stable(ctl_word) && s_axi_bvalid;
    endproperty
    a_cap_write: assert property (p_cap_write) else $error("capability write had effect");

    property p_reserved;
        @(posedge aclk) disable iff (!aresetn)
        ctl_word[31:16] == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_reset_val;
        @(posedge aclk) !aresetn |=> brownout_filter_count == FILTER_COUNT_RESET
            && brownout_noise_check && !brownout_reset_select;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad control reset");

    c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
    c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
    c_filtered: cover property (@(posedge aclk) disable iff (!aresetn)
        state == FLT_WAIT ##1 brownout_irq_req);
    c_noise: cover property (@(posedge aclk) disable iff (!aresetn)
        state == FLT_WAIT ##1 state == FLT_IDLE);
endmodule

// ---- testbench/cbc_brownout_partner.sv ----
// Model of the brown-out detector output and the free-running internal oscillator.
`timescale 1ns/10ps

module cbc_brownout_partner (
    input wire logic aclk,
    output logic brownout_detector,
    output logic internal_oscillator
);
    // ****************************************************************
    // Internal oscillator
    // ****************************************************************
    // The oscillator runs free at 80 ns a period, well under a quarter of the 200 MHz bus
    // clock, and starts out of phase with it so edges never line up with aclk.
    initial begin
        internal_oscillator = 1'b0;
        #7;
        forever #40 internal_oscillator = ~internal_oscillator;
    end

    // ****************************************************************
    // Detector output
    // ****************************************************************
    initial brownout_detector = 1'b0;

    // Holds the detector asserted for the given number of bus clock cycles.
    task automatic pulse(input int cycles);
        @(posedge aclk);
        brownout_detector <= 1'b1;
        repeat (cycles) @(posedge aclk);
        brownout_detector <= 1'b0;
    endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking testbench for the capability and brown-out control block.
`timescale 1ns/10ps

module tb;
    import cbc_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, rd_resp;
    logic [31:0] s_axi_rdata, rdat;
    logic brownout_detector, internal_oscillator, brownout_reset_req, brownout_irq_req, hit;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [11:0] cap_addr [3] = '{ADDR_PERIPHERAL_PRESENCE_B, ADDR_PIN_PRESENCE, ADDR_PORT_PRESENCE};
    logic [31:0] cap_exp [3] = '{32'h0107_0113, 32'h173F_01FF, 32'h0000_001F};

    initial forever #2.5 aclk = ~aclk;

    cbc_capability_brownout uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .brownout_detector(brownout_detector), .internal_oscillator(internal_oscillator),
        .brownout_reset_req(brownout_reset_req), .brownout_irq_req(brownout_irq_req));

    cbc_brownout_partner bo (.aclk(aclk), .brownout_detector(brownout_detector),
        .internal_oscillator(internal_oscillator));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Ready is judged at the falling edge so the handshake edge itself is never raced.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        logic aw_go, w_go, aw_now, w_now;
        aw_go = 1'b0;
        w_go = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_go && w_go)) begin
            @(negedge aclk);
            aw_now = s_axi_awvalid && (s_axi_awready === 1'b1);
            w_now = s_axi_wvalid && (s_axi_wready === 1'b1);
            @(posedge aclk);
            if (aw_now) begin
                s_axi_awvalid <= 1'b0;
                aw_go = 1'b1;
            end
            if (w_now) begin
                s_axi_wvalid <= 1'b0;
                w_go = 1'b1;
            end
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        rd_resp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    // The whole sequence needs under two thousand cycles; twenty thousand leaves ample margin.
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        $display("[ERR] watchdog expected finish seen hang");
        end_of_test();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_BROWNOUT_CONTROL);
        check("control_reset", rdat, 32'h0000_7FFD);
        for (int i = 0; i < 3; i++) begin
            rd(cap_addr[i]);
            check("capability", rdat, cap_exp[i]);
            check("cap_rresp", {30'h0, rd_resp}, {30'h0, RESP_OKAY});
        end
        $display("test reset_values done");

        for (int i = 0; i < 3; i++) begin
            wr(cap_addr[i], 32'hFFFF_FFFF);
            check("cap_bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
            rd(cap_addr[i]);
            check("cap_after_write", rdat, cap_exp[i]);
        end
        wr(12'h020, 32'hFFFF_FFFF);
        rd(12'h020);
        check("unmapped", rdat, 32'h0000_0000);
        $display("test capability_writes done");

        // Only the low lane is strobed, so the upper count bits keep their reset value.
        wr(ADDR_BROWNOUT_CONTROL, 32'hFFFF_FF51, 4'h1);
        rd(ADDR_BROWNOUT_CONTROL);
        check("control_lane0", rdat, 32'h0000_7F51);
        // Filter count 20 with noise check on; upper reserved lanes are written but stay 0.
        wr(ADDR_BROWNOUT_CONTROL, 32'hFFFF_0051);
        rd(ADDR_BROWNOUT_CONTROL);
        check("control_rw", rdat, 32'h0000_0051);
        $display("test control_write done");

        hit = 1'b0;
        fork
            bo.pulse(100);
            repeat (500) begin
                @(negedge aclk);
                hit = hit | brownout_irq_req | brownout_reset_req;
            end
        join
        check("noise_rejected", {31'h0, hit}, 32'h0000_0000);
        fork
            bo.pulse(600);
            begin
                repeat (250) @(negedge aclk);
                check("irq_before_wait", {31'h0, brownout_irq_req}, 32'h0000_0000);
                repeat (150) @(negedge aclk);
                check("irq_after_wait", {31'h0, brownout_irq_req}, 32'h0000_0001);
                check("reset_in_irq_mode", {31'h0, brownout_reset_req}, 32'h0000_0000);
            end
        join
        repeat (10) @(negedge aclk);
        check("irq_released", {31'h0, brownout_irq_req}, 32'h0000_0000);
        $display("test noise_filter done");

        for (int m = 0; m < 2; m++) begin
            wr(ADDR_BROWNOUT_CONTROL, (m == 1) ? 32'h0000_0002 : 32'h0000_0000);
            fork
                bo.pulse(50);
                begin
                    repeat (10) @(negedge aclk);
                    check("immediate", {30'h0, brownout_reset_req, brownout_irq_req},
                        (m == 1) ? 32'h0000_0002 : 32'h0000_0001);
                end
            join
            repeat (10) @(negedge aclk);
            check("released", {30'h0, brownout_reset_req, brownout_irq_req}, 32'h0000_0000);
        end
        $display("test immediate_report done");

        // A count above 10,000 keeps the filter waiting far longer than the run, so a
        // mid-run reset is what ends the wait.
        wr(ADDR_BROWNOUT_CONTROL, 32'h0000_9C45);
        rd(ADDR_BROWNOUT_CONTROL);
        check("control_long", rdat, 32'h0000_9C45);
        fork
            bo.pulse(400);
            begin
                repeat (300) @(negedge aclk);
                check("long_wait_quiet", {30'h0, brownout_reset_req, brownout_irq_req},
                    32'h0000_0000);
            end
        join
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_BROWNOUT_CONTROL);
        check("control_after_reset", rdat, 32'h0000_7FFD);
        check("reqs_after_reset", {30'h0, brownout_reset_req, brownout_irq_req},
            32'h0000_0000);
        $display("test long_count_reset done");
        end_of_test();
    end
endmodule
